// >>> cfgl_loader.v
// What this block does
// - Start flash load only on rising reset pin after minimum low time.
// - User logic released only after FRAME_WORDS words are counted and the buffer drains; passive and JTAG words that meet a full buffer are lost.
// - Active mode: device drives flash clock and runs the sequence.
// - Controller itself sends every instruction and address to the flash.
// - First instruction sent is release-from-power-down.
// - Wait at least 30 us after wake before fast read.
// - Fast read starts at address zero, read sequentially.
// - A complete load is also accepted through the JTAG port.
// - Mask memory option loads from on-chip memory, not flash.
// - Largest packages: no multi-image in active x1 mode.
`timescale 1ns/100ps
`include "cfgl_regs.vh"
module cfgl_loader #(
  parameter FRAME_WORDS = 16,
  parameter MASK_MEM_FITTED = 0,
  parameter BIG_PACKAGE = 0,
  parameter WAKE_CYCLES = `CFGL_WAKE_US * `CFGL_CLK_MHZ,
  parameter CLK_DIV = 4
) (
  input wire CLK_I,
  input wire SYS_RST_I,
  input wire CONFIG_RESET_LOW_I,
  input wire [1:0] MODE_I,
  input wire [2:0] WIDTH_I,
  input wire MULTI_IMAGE_I,
  output reg FL_SCK_O,
  output reg FL_CS_N_O,
  output reg [3:0] FL_IO_O,
  output reg [3:0] FL_IO_OE_O,
  input wire [3:0] FL_IO_I,
  input wire PS_CLK_I,
  input wire PS_EN_I,
  input wire [31:0] PS_DATA_I,
  input wire TCK_I,
  input wire TDI_I,
  input wire JTAG_LOAD_I,
  input wire [31:0] MASK_WORD_I,
  output reg [9:0] MASK_ADDR_O,
  output wire [31:0] CELL_DATA_O,
  output wire CELL_VALID_O,
  input wire CELL_READY_I,
  output reg USER_ENABLE_O,
  output reg MODE_ERROR_O
);
  localparam RST_LOW_CYC = (`CFGL_RST_LOW_NS * `CFGL_CLK_MHZ +
    `CFGL_NS_PER_US - 1) / `CFGL_NS_PER_US;
  localparam S_IDLE = 3'h0, S_WAKE = 3'h1, S_WAIT = 3'h2, S_CMD = 3'h3;
  localparam S_DATA = 3'h4, S_DONE = 3'h5, S_ERR = 3'h6;
  // ----------------------------------------
  // Pin sync: three stages, change on agree
  // ----------------------------------------
  reg [2:0] rstp_ff, psclk_ff, tck_ff;
  reg rstp_q_ff, psclk_q_ff, tck_q_ff;
  always @(posedge CLK_I) begin
    rstp_ff <= {rstp_ff[1:0], CONFIG_RESET_LOW_I};
    psclk_ff <= {psclk_ff[1:0], PS_CLK_I};
    tck_ff <= {tck_ff[1:0], TCK_I};
    if (rstp_ff[2] == rstp_ff[1]) rstp_q_ff <= rstp_ff[2];
    if (psclk_ff[2] == psclk_ff[1]) psclk_q_ff <= psclk_ff[2];
    if (tck_ff[2] == tck_ff[1]) tck_q_ff <= tck_ff[2];
  end
  wire ps_rise = (psclk_ff[2] == psclk_ff[1]) && psclk_ff[2] && !psclk_q_ff;
  wire tck_rise = (tck_ff[2] == tck_ff[1]) && tck_ff[2] && !tck_q_ff;
  wire rst_rise = (rstp_ff[2] == rstp_ff[1]) && rstp_ff[2] && !rstp_q_ff;
  // ----------------------------------------
  // Reset pin low-time qualifier
  // ----------------------------------------
  reg [15:0] low_cnt_ff;
  always @(posedge CLK_I) begin
    if (SYS_RST_I || rstp_q_ff) low_cnt_ff <= 16'h0000;
    else if (low_cnt_ff < RST_LOW_CYC) low_cnt_ff <= low_cnt_ff + 16'h0001;
  end
  wire start = rst_rise && (low_cnt_ff >= RST_LOW_CYC);
  // ----------------------------------------
  // Divider for flash clock enable
  // ----------------------------------------
  reg [7:0] div_ff;
  wire tick = (div_ff == CLK_DIV - 1);
  always @(posedge CLK_I) begin
    if (SYS_RST_I || tick) div_ff <= 8'h00;
    else div_ff <= div_ff + 8'h01;
  end
  // ----------------------------------------
  // Main sequencer
  // ----------------------------------------
  reg [2:0] st_ff;
  reg [1:0] mode_ff;
  reg [2:0] wsel_ff;
  reg [31:0] sh_ff;
  reg [5:0] bit_ff;
  reg [19:0] wait_ff;
  reg [31:0] acc_ff;
  reg [5:0] acc_n_ff;
  reg [15:0] words_ff;
  reg ph_ff;
  reg wr_ff;
  reg [31:0] wd_ff;
  wire fifo_rdy;
  wire [5:0] wbits = (wsel_ff == `CFGL_W1) ? 6'd1 :
    (wsel_ff == `CFGL_W2) ? 6'd2 : (wsel_ff == `CFGL_W4) ? 6'd4 :
    (wsel_ff == `CFGL_W8) ? 6'd8 : (wsel_ff == `CFGL_W16) ? 6'd16 : 6'd32;
  wire bad_w = (MODE_I == `CFGL_MODE_ACTIVE && WIDTH_I > `CFGL_W4) ||
    (MODE_I == `CFGL_MODE_JTAG && WIDTH_I != `CFGL_W1) ||
    (WIDTH_I > `CFGL_W32) || (MODE_I == 2'h3);
  wire bad_mi = BIG_PACKAGE && MULTI_IMAGE_I &&
    MODE_I == `CFGL_MODE_ACTIVE && WIDTH_I == `CFGL_W1;
  wire use_mask = (MASK_MEM_FITTED != 0) && MODE_I == `CFGL_MODE_ACTIVE;
  wire mask_run = (MASK_MEM_FITTED != 0) && mode_ff == `CFGL_MODE_ACTIVE;
  wire [31:0] wake_word = {`CFGL_CMD_WAKE, 24'h000000};
  wire [31:0] fread_word = {`CFGL_CMD_FREAD, `CFGL_START_ADDR};
  // Unit arrives from the selected source this cycle
  reg unit_ok;
  reg [31:0] unit_d;
  always @* begin
    unit_ok = 1'b0;
    unit_d = 32'h00000000;
    if (mode_ff == `CFGL_MODE_PASSIVE) begin
      unit_ok = ps_rise && PS_EN_I;
      unit_d = PS_DATA_I;
    end else if (mode_ff == `CFGL_MODE_JTAG) begin
      unit_ok = tck_rise && JTAG_LOAD_I;
      unit_d = {31'h0, TDI_I};
    end else begin
      unit_ok = tick && ph_ff;
      unit_d = {28'h0, FL_IO_I};
    end
  end
  wire [31:0] merged = (wbits == 6'd32) ? unit_d :
    ((acc_ff << wbits) | (unit_d & ((32'h1 << wbits) - 32'h1)));
  always @(posedge CLK_I) begin
    wr_ff <= 1'b0;
    if (SYS_RST_I) begin
      st_ff <= S_IDLE;
      FL_SCK_O <= 1'b0;
      FL_CS_N_O <= 1'b1;
      FL_IO_O <= 4'h0;
      FL_IO_OE_O <= 4'h0;
      USER_ENABLE_O <= 1'b0;
      MODE_ERROR_O <= 1'b0;
      MASK_ADDR_O <= 10'h000;
      mode_ff <= `CFGL_MODE_ACTIVE;
      wsel_ff <= `CFGL_W1;
      ph_ff <= 1'b0;
      sh_ff <= 32'h0;
      bit_ff <= 6'h0;
      wait_ff <= 20'h0;
      acc_ff <= 32'h0;
      acc_n_ff <= 6'h0;
      words_ff <= 16'h0;
      wd_ff <= 32'h0;
    end else begin
      if (start) begin
        // Memory cells lost: user logic held until reload completes
        USER_ENABLE_O <= 1'b0;
        MODE_ERROR_O <= 1'b0;
        mode_ff <= MODE_I;
        wsel_ff <= WIDTH_I;
        acc_ff <= 32'h0;
        acc_n_ff <= 6'h0;
        words_ff <= 16'h0;
        MASK_ADDR_O <= 10'h000;
        // Cut frame ends on a restart, except a new active flash load, which keeps select low
        FL_CS_N_O <= 1'b1;
        FL_SCK_O <= 1'b0;
        FL_IO_OE_O <= 4'h0;
        if (bad_w || bad_mi) begin
          st_ff <= S_ERR;
        end else if (use_mask) begin
          st_ff <= S_DATA;
        end else if (MODE_I == `CFGL_MODE_ACTIVE) begin
          FL_CS_N_O <= 1'b0;
          FL_IO_OE_O <= 4'h1;
          sh_ff <= wake_word;
          FL_IO_O <= {3'h0, wake_word[31]};
          bit_ff <= 6'd8;
          ph_ff <= 1'b0;
          st_ff <= S_WAKE;
        end else begin
          st_ff <= S_DATA;
        end
      end else begin
        case (st_ff)
          S_WAKE, S_CMD: begin
            if (tick) begin
              ph_ff <= !ph_ff;
              FL_SCK_O <= !ph_ff;
              if (ph_ff) begin
                // Next bit moves on the fall, so it is stable at the rise
                FL_IO_O <= {3'h0, sh_ff[30]};
                sh_ff <= {sh_ff[30:0], 1'b0};
                bit_ff <= bit_ff - 6'h01;
                if (bit_ff == 6'h01) begin
                  if (st_ff == S_WAKE) begin
                    FL_CS_N_O <= 1'b1;
                    FL_IO_OE_O <= 4'h0;
                    wait_ff <= 20'h0;
                    st_ff <= S_WAIT;
                  end else begin
                    // Dummy byte clocked as zeros, then turn bus round
                    FL_IO_OE_O <= 4'h0;
                    st_ff <= S_DATA;
                  end
                end
              end
            end
          end
          S_WAIT: begin
            wait_ff <= wait_ff + 20'h1;
            if (wait_ff >= WAKE_CYCLES - 1) begin
              FL_CS_N_O <= 1'b0;
              FL_IO_OE_O <= 4'h1;
              sh_ff <= fread_word;
              FL_IO_O <= {3'h0, fread_word[31]};
              bit_ff <= 6'd32 + `CFGL_DUMMY_BITS;
              ph_ff <= 1'b0;
              st_ff <= S_CMD;
            end
          end
          S_DATA: begin
            if (mask_run) begin
              // Every other cycle: full flag lags the pending write
              if (fifo_rdy && !wr_ff) begin
                wd_ff <= MASK_WORD_I;
                wr_ff <= 1'b1;
                MASK_ADDR_O <= MASK_ADDR_O + 10'h001;
                words_ff <= words_ff + 16'h1;
                if (words_ff == FRAME_WORDS - 1) st_ff <= S_DONE;
              end
            end else begin
              if (mode_ff == `CFGL_MODE_ACTIVE && tick &&
                  (ph_ff || fifo_rdy)) begin
                ph_ff <= !ph_ff;
                // No rise while the buffer is full, so no unit is lost
                FL_SCK_O <= !ph_ff;
              end
              if (unit_ok) begin
                if (acc_n_ff + wbits >= 6'd32) begin
                  wd_ff <= merged;
                  wr_ff <= 1'b1;
                  acc_n_ff <= 6'h0;
                  words_ff <= words_ff + 16'h1;
                  if (words_ff == FRAME_WORDS - 1) st_ff <= S_DONE;
                end else begin
                  acc_ff <= merged;
                  acc_n_ff <= acc_n_ff + wbits;
                end
              end
            end
          end
          S_DONE: begin
            FL_CS_N_O <= 1'b1;
            FL_SCK_O <= 1'b0;
            if (!CELL_VALID_O && !wr_ff) USER_ENABLE_O <= 1'b1;
            st_ff <= S_IDLE;
          end
          S_ERR: begin
            MODE_ERROR_O <= 1'b1;
            st_ff <= S_IDLE;
          end
          default: begin
            st_ff <= S_IDLE;
          end
        endcase
        if (st_ff == S_IDLE && !USER_ENABLE_O && words_ff == FRAME_WORDS &&
            !CELL_VALID_O) begin
          USER_ENABLE_O <= 1'b1;
        end
      end
    end
  end
  cfgl_fifo #(.WIDTH(32), .DEPTH(8), .AW(3)) u_fifo (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .wr_data_i(wd_ff),
    .wr_valid_i(wr_ff),
    .wr_ready_o(fifo_rdy),
    .rd_data_o(CELL_DATA_O),
    .rd_valid_o(CELL_VALID_O),
    .rd_ready_i(CELL_READY_I)
  );
endmodule

// >>> cfgl_regs.vh
`ifndef CFGL_REGS_VH
`define CFGL_REGS_VH
// ----------------------------------------
// Flash instructions and address
// ----------------------------------------
`define CFGL_CMD_WAKE 8'hAB
`define CFGL_CMD_FREAD 8'h0B
`define CFGL_START_ADDR 24'h000000
`define CFGL_DUMMY_BITS 6'h08
// ----------------------------------------
// Timing
// ----------------------------------------
`define CFGL_CLK_MHZ 100
`define CFGL_WAKE_US 30
`define CFGL_RST_LOW_NS 1000
`define CFGL_NS_PER_US 1000
// ----------------------------------------
// Modes and widths
// ----------------------------------------
`define CFGL_MODE_ACTIVE 2'h0
`define CFGL_MODE_PASSIVE 2'h1
`define CFGL_MODE_JTAG 2'h2
`define CFGL_W1 3'h0
`define CFGL_W2 3'h1
`define CFGL_W4 3'h2
`define CFGL_W8 3'h3
`define CFGL_W16 3'h4
`define CFGL_W32 3'h5
`endif

// >>> cfgl_fifo.v
`timescale 1ns/100ps
module cfgl_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_i,
  input wire rst_i,
  input wire [WIDTH-1:0] wr_data_i,
  input wire wr_valid_i,
  output wire wr_ready_o,
  output wire [WIDTH-1:0] rd_data_o,
  output wire rd_valid_o,
  input wire rd_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wp_ff;
  reg [AW:0] rp_ff;
  wire full = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
  wire empty = (wp_ff == rp_ff);
  assign wr_ready_o = !full;
  assign rd_valid_o = !empty;
  assign rd_data_o = mem[rp_ff[AW-1:0]];
  always @(posedge clk_i) begin
    if (wr_valid_i && !full) begin
      mem[wp_ff[AW-1:0]] <= wr_data_i;
    end
  end
  always @(posedge clk_i) begin
    if (rst_i) begin
      wp_ff <= {(AW+1){1'b0}};
      rp_ff <= {(AW+1){1'b0}};
    end else begin
      if (wr_valid_i && !full) begin
        wp_ff <= wp_ff + 1'b1;
      end
      if (rd_ready_i && !empty) begin
        rp_ff <= rp_ff + 1'b1;
      end
    end
  end
endmodule

// >>> cfgl_loader_sva.sv
`timescale 1ns/100ps
module cfgl_loader_sva #(
  parameter WAKE_CYCLES = 3000
) (
  input wire CLK_I,
  input wire SYS_RST_I,
  input wire CONFIG_RESET_LOW_I,
  input wire FL_SCK_O,
  input wire FL_CS_N_O,
  input wire [3:0] FL_IO_O,
  input wire [3:0] FL_IO_OE_O,
  input wire CELL_VALID_O,
  input wire USER_ENABLE_O,
  input wire MODE_ERROR_O
);
  int hi_ff;
  int nfr_ff;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // Idle select time and frames since the pin rose
  always @(posedge CLK_I) begin
    hi_ff <= FL_CS_N_O ? hi_ff + 1 : 0;
    if (SYS_RST_I || !CONFIG_RESET_LOW_I) nfr_ff <= 0;
    else if ($fell(FL_CS_N_O)) nfr_ff <= nfr_ff + 1;
  end
  start_pin_a: assert property ($fell(FL_CS_N_O) |-> CONFIG_RESET_LOW_I)
    else $error("select while pin low");
  load_first_a: assert property ($rose(USER_ENABLE_O) |->
    !CELL_VALID_O && FL_CS_N_O && !MODE_ERROR_O) else $error("early enable");
  bad_cfg_a: assert property (MODE_ERROR_O |->
    FL_CS_N_O && !USER_ENABLE_O) else $error("load despite error");
  oe_sel_a: assert property (FL_IO_OE_O[0] |-> !FL_CS_N_O)
    else $error("drive while deselected");
  io_hold_a: assert property ($rose(FL_SCK_O) |-> $stable(FL_IO_O[0]))
    else $error("data moved at clock rise");
  sck_high_a: assert property ($rose(FL_SCK_O) |-> FL_SCK_O [*4])
    else $error("short clock high");
  sck_sel_a: assert property (FL_SCK_O |-> !FL_CS_N_O)
    else $error("clock while deselected");
  wake_gap_a: assert property ($fell(FL_CS_N_O) && nfr_ff == 1 |->
    hi_ff >= WAKE_CYCLES) else $error("wake wait too short");
  cover property ($rose(USER_ENABLE_O));
  cover property ($rose(MODE_ERROR_O));
  cover property ($fell(FL_CS_N_O) && nfr_ff == 1);
endmodule
bind cfgl_loader cfgl_loader_sva #(.WAKE_CYCLES(WAKE_CYCLES)) u_sva (
  .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
  .CONFIG_RESET_LOW_I(CONFIG_RESET_LOW_I), .FL_SCK_O(FL_SCK_O),
  .FL_CS_N_O(FL_CS_N_O), .FL_IO_O(FL_IO_O), .FL_IO_OE_O(FL_IO_OE_O),
  .CELL_VALID_O(CELL_VALID_O), .USER_ENABLE_O(USER_ENABLE_O),
  .MODE_ERROR_O(MODE_ERROR_O));

// >>> cfgl_flash_model.sv
`timescale 1ns/100ps
module cfgl_flash_model (
  input wire clk_i,
  input wire sck_i,
  input wire cs_n_i,
  input wire si_i,
  output logic [3:0] so_o
);
  int bits;
  int frames;
  int gap;
  int edges;
  logic [7:0] wake_cmd;
  logic [31:0] read_hdr;
  initial so_o = 4'h0;
  task clear();
    frames = 0;
    gap = 0;
    edges = 0;
  endtask
  always @(negedge cs_n_i) begin
    frames++;
    bits = 0;
  end
  always @(posedge clk_i) if (cs_n_i && frames == 1) gap++;
  always @(posedge sck_i) if (!cs_n_i) begin
    bits++;
    edges++;
    if (frames == 1) wake_cmd = {wake_cmd[6:0], si_i};
    if (frames == 2 && bits <= 32) read_hdr = {read_hdr[30:0], si_i};
  end
  // Data only after opcode, address and dummy bits
  always @(negedge sck_i) if (!cs_n_i) so_o = (bits >= 40) ? 4'h5 : 4'hA;
  // Released lines must not look still driven
  always @(posedge cs_n_i) so_o = ~so_o;
endmodule

// >>> tb_top.sv
`timescale 1ns/100ps
`include "cfgl_regs.vh"
module tb_top;
  logic clk = 0, rst = 1, pin = 1, multi = 0, rdy = 0, lclk = 0, len = 0;
  logic tdi = 0;
  logic [1:0] mode = 0;
  logic [2:0] width = 0;
  logic [31:0] pdat = 0;
  wire sck, csn, uen, merr, cval;
  wire [3:0] io_o, io_i, io_oe;
  wire [9:0] maddr;
  wire [31:0] cdat;
  int miscompares = 0;
  int comparisons = 0;
  initial forever #5 clk = ~clk;
  cfgl_loader #(.WAKE_CYCLES(20), .BIG_PACKAGE(1)) u_dut (
    .CLK_I(clk), .SYS_RST_I(rst), .CONFIG_RESET_LOW_I(pin), .MODE_I(mode),
    .WIDTH_I(width), .MULTI_IMAGE_I(multi), .FL_SCK_O(sck), .FL_CS_N_O(csn),
    .FL_IO_O(io_o), .FL_IO_OE_O(io_oe), .FL_IO_I(io_i), .PS_CLK_I(lclk),
    .PS_EN_I(len && mode == 1), .PS_DATA_I(pdat), .TCK_I(lclk), .TDI_I(tdi),
    .JTAG_LOAD_I(len && mode == 2), .MASK_WORD_I(32'h0), .MASK_ADDR_O(maddr),
    .CELL_DATA_O(cdat), .CELL_VALID_O(cval), .CELL_READY_I(rdy),
    .USER_ENABLE_O(uen), .MODE_ERROR_O(merr));
  cfgl_flash_model u_flash (.clk_i(clk), .sck_i(sck), .cs_n_i(csn),
    .si_i(io_o[0]), .so_o(io_i));
  task check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task start(logic [1:0] m, logic [2:0] w, logic mi, int low);
    rst = 1;
    repeat (6) @(negedge clk);
    {rst, mode, width, multi, pin} = {1'b0, m, w, mi, 1'b0};
    u_flash.clear();
    repeat (low) @(negedge clk);
    pin = 1;
  endtask
  // Optional stall first: buffer fills and the flash clock must stop
  task drain(logic [31:0] base, logic [31:0] inc, logic stall);
    int e;
    if (stall) begin
      repeat (4000) @(negedge clk);
      e = u_flash.edges;
      repeat (40) @(negedge clk);
      check("sck stall", u_flash.edges, e);
      check("early enable", uen, 0);
    end
    rdy = 1;
    for (int i = 0; i < 16; i++) begin
      for (int t = 0; t < 5000 && !cval; t++) @(negedge clk);
      if (!cval) begin
        miscompares++;
        stop_test();
      end
      check("cell word", cdat, base + i * inc);
      @(negedge clk);
    end
    for (int t = 0; t < 100 && !uen; t++) @(negedge clk);
    check("user enable", uen, 1);
    check("buffer empty", cval, 0);
    rdy = 0;
  endtask
  task t_refuse();
    logic [5:0] cfg [4] = '{6'h01, 6'h30, 6'h06, 6'h00};
    for (int k = 0; k < 4; k++) begin
      start(cfg[k][5:4], cfg[k][3:1], cfg[k][0], k < 3 ? 120 : 50);
      repeat (300) @(negedge clk);
      check("mode error", merr, k < 3);
      check("no select", csn, 1);
    end
    $display("test refusals done");
  endtask
  task t_flash(logic [2:0] w, logic mi, logic [31:0] exp);
    start(`CFGL_MODE_ACTIVE, w, mi, 120);
    drain(exp, 0, 1);
    check("wake", u_flash.wake_cmd, `CFGL_CMD_WAKE);
    check("hdr", u_flash.read_hdr, {`CFGL_CMD_FREAD, 24'h0});
    check("wake gap", u_flash.gap >= 20, 1);
    check("frames", u_flash.frames, 2);
    check("bus turned", io_oe, 0);
    check("mask unused", maddr, 0);
    $display("test flash width %0d done", w);
  endtask
  // Link clock of 125 ns runs only while words are sent
  task t_link(logic [1:0] m, logic [2:0] w);
    start(m, w, 0, 120);
    fork
      begin
        len = 1;
        for (int i = 0; i < 16; i++) begin
          pdat = 32'h5A00_0000 + i;
          for (int b = 31; b >= 0; b--) begin
            tdi = pdat[b];
            #62.5 lclk = 1;
            #62.5 lclk = 0;
            if (m == 1) break;
          end
        end
        len = 0;
      end
      drain(32'h5A00_0000, 1, 0);
    join
    check("link loaded", uen, 1);
    $display("test link mode %0d done", m);
  endtask
  initial begin
    t_refuse();
    t_flash(`CFGL_W1, 0, 32'hFFFF_FFFF);
    t_flash(`CFGL_W2, 1, 32'h5555_5555);
    t_flash(`CFGL_W4, 1, 32'h5555_5555);
    t_link(`CFGL_MODE_PASSIVE, `CFGL_W32);
    t_link(`CFGL_MODE_JTAG, `CFGL_W1);
    stop_test();
  end
  initial begin
    #900000;
    miscompares++;
    stop_test();
  end
endmodule
